// ### modbus_server_pkg.sv
// constants shared by the request interpreter and its check-sum engine
package modbus_server_pkg;
  // function codes and exception codes
  localparam logic [7:0] FC_READ = 8'h03;
  localparam logic [7:0] FC_WRITE = 8'h06;
  localparam logic [7:0] EXC_FLAG = 8'h80;
  localparam logic [7:0] EXC_ILL_FUNC = 8'h01;
  localparam logic [7:0] EXC_ILL_ADDR = 8'h02;
  localparam logic [7:0] EXC_ILL_VALUE = 8'h03;
  // read quantity bounds and size of the holding register table
  localparam logic [15:0] QTY_MIN = 16'h0001;
  localparam logic [15:0] QTY_MAX = 16'h007d;
  localparam logic [16:0] TABLE_SIZE = 17'h0002c;
  // frame layout: byte positions and lengths
  localparam logic [8:0] REQ_LEN = 9'h008;
  localparam logic [8:0] MIN_LEN = 9'h004;
  localparam logic [8:0] FRAME_MAX = 9'h100;
  localparam logic [8:0] HDR_BYTES = 9'h003;
  localparam logic [8:0] ECHO_BYTES = 9'h006;
  localparam int BUF_BYTES = 6;
  // check-sum constants
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'ha001;
  // inter-frame silence, printed time and derived cycle count
  localparam int CLK_PERIOD_NS = 50;
  localparam int SILENCE_NS = 2000000;
  localparam int SILENCE_CYC =
    (SILENCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // kinds of answer
  localparam logic [1:0] KIND_EXC = 2'h0;
  localparam logic [1:0] KIND_READ = 2'h1;
  localparam logic [1:0] KIND_WRITE = 2'h2;
  // reset values
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [15:0] WORD_RST = 16'h0000;
endpackage

// ### crc16_byte.sv
// running 16-bit frame check sum, one byte per enabled clock
`timescale 1ns/1ps
module crc16_byte (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic clear_i,
  input wire logic en_i,
  input wire logic [7:0] data_i,
  output logic [15:0] crc_o
);
  logic [15:0] crc_r;
  logic [15:0] crc_nxt;

  // clear restarts from the seed; with en it also folds the first byte in
  always_comb begin
    logic [15:0] c;
    c = clear_i ? modbus_server_pkg::CRC_INIT : crc_r;
    if (en_i) begin
      c = c ^ {8'h00, data_i};
      for (int i = 0; i < 8; i++) begin
        c = c[0] ? ((c >> 1) ^ modbus_server_pkg::CRC_POLY) : (c >> 1);
      end
    end
    crc_nxt = c;
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      crc_r <= modbus_server_pkg::CRC_INIT;
    end else begin
      crc_r <= crc_nxt;
    end
  end

  assign crc_o = crc_r;
endmodule

// ### modbus_rtu_register_server.sv
// request interpreter for a serial-line holding register server
`timescale 1ns/1ps
module modbus_rtu_register_server #(
  parameter int SILENCE_CYCLES = modbus_server_pkg::SILENCE_CYC
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [7:0] node_addr_i,
  input wire logic [7:0] rx_byte_i,
  input wire logic rx_valid_i,
  input wire logic rx_err_i,
  output logic [7:0] tx_byte_o,
  output logic tx_valid_o,
  input wire logic tx_ready_i,
  output logic [15:0] reg_addr_o,
  output logic reg_rd_o,
  output logic reg_wr_o,
  output logic [15:0] reg_wdata_o,
  input wire logic [15:0] reg_rdata_i
);
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_RECV = 7'h02,
    ST_EXEC = 7'h04,
    ST_LOAD = 7'h08,
    ST_FETCH = 7'h10,
    ST_GRAB = 7'h20,
    ST_SEND = 7'h40
  } state_t;

  state_t state_r, state_nxt;
  logic [19:0] gap_r, gap_nxt;
  logic [8:0] len_r, len_nxt;
  logic bad_r, bad_nxt;
  logic [7:0] buf_r [0:5];
  logic [7:0] buf_nxt [0:5];
  logic [1:0] kind_r, kind_nxt;
  logic [7:0] rfc_r, rfc_nxt;
  logic [7:0] exc_r, exc_nxt;
  logic [8:0] body_r, body_nxt;
  logic [8:0] idx_r, idx_nxt;
  logic [15:0] word_r, word_nxt;
  logic word_ok_r, word_ok_nxt;
  logic [15:0] crc_hold_r, crc_hold_nxt;
  logic [7:0] tx_byte_r, tx_byte_nxt;
  logic tx_valid_r, tx_valid_nxt;
  logic [15:0] reg_addr_r, reg_addr_nxt;
  logic reg_rd_r, reg_rd_nxt;
  logic reg_wr_r, reg_wr_nxt;
  logic [15:0] reg_wdata_r, reg_wdata_nxt;
  logic crc_clear, crc_en;
  logic [7:0] crc_data;
  logic [15:0] crc_val;
  logic silent;
  logic [15:0] req_addr, req_val;
  logic [16:0] read_end;
  logic [8:0] k;

  // one engine serves both directions: the line is half duplex
  crc16_byte crc_u (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .clear_i(crc_clear),
    .en_i(crc_en),
    .data_i(crc_data),
    .crc_o(crc_val)
  );

  assign silent = (gap_r >= 20'(SILENCE_CYCLES));
  assign req_addr = {buf_r[2], buf_r[3]};
  assign req_val = {buf_r[4], buf_r[5]};
  assign read_end = {1'b0, req_addr} + {1'b0, req_val};
  assign k = idx_r - modbus_server_pkg::HDR_BYTES;

  // frame sequencing, request decoding and answer generation
  always_comb begin
    state_nxt = state_r;
    gap_nxt = gap_r;
    len_nxt = len_r;
    bad_nxt = bad_r;
    buf_nxt = buf_r;
    kind_nxt = kind_r;
    rfc_nxt = rfc_r;
    exc_nxt = exc_r;
    body_nxt = body_r;
    idx_nxt = idx_r;
    word_nxt = word_r;
    word_ok_nxt = word_ok_r;
    crc_hold_nxt = crc_hold_r;
    tx_byte_nxt = tx_byte_r;
    tx_valid_nxt = tx_valid_r;
    reg_addr_nxt = reg_addr_r;
    reg_rd_nxt = 1'b0;
    reg_wr_nxt = 1'b0;
    reg_wdata_nxt = reg_wdata_r;
    crc_clear = 1'b0;
    crc_en = 1'b0;
    crc_data = rx_byte_i;
    // silence timer: any character restarts it, saturates when quiet
    if (rx_valid_i) begin
      gap_nxt = '0;
    end else if (!silent) begin
      gap_nxt = gap_r + 20'h00001;
    end
    unique case (state_r)
      ST_IDLE: begin
        // a character after silence opens a frame with its address
        if (rx_valid_i && silent) begin
          state_nxt = ST_RECV;
          crc_clear = 1'b1;
          crc_en = 1'b1;
          len_nxt = 9'h001;
          bad_nxt = rx_err_i;
          buf_nxt[0] = rx_byte_i;
        end
      end
      ST_RECV: begin
        if (rx_valid_i) begin
          crc_en = 1'b1;
          if (len_r < 9'(modbus_server_pkg::BUF_BYTES)) begin
            buf_nxt[len_r[2:0]] = rx_byte_i;
          end
          if (len_r == modbus_server_pkg::FRAME_MAX) begin
            bad_nxt = 1'b1; // overlong frame is discarded
          end else begin
            len_nxt = len_r + 9'h001;
          end
          if (rx_err_i) begin
            bad_nxt = 1'b1;
          end
        end else if (silent) begin
          state_nxt = ST_EXEC;
        end
      end
      ST_EXEC: begin
        // residue over message plus its check bytes is zero when intact
        state_nxt = ST_IDLE;
        if (!bad_r && crc_val == 16'h0000
            && len_r >= modbus_server_pkg::MIN_LEN
            && buf_r[0] == node_addr_i) begin
          state_nxt = ST_LOAD;
          crc_clear = 1'b1;
          crc_data = 8'h00;
          idx_nxt = '0;
          word_ok_nxt = 1'b0;
          kind_nxt = modbus_server_pkg::KIND_EXC;
          rfc_nxt = buf_r[1] | modbus_server_pkg::EXC_FLAG;
          body_nxt = modbus_server_pkg::HDR_BYTES;
          if (buf_r[1] == modbus_server_pkg::FC_READ) begin
            if (len_r != modbus_server_pkg::REQ_LEN
                || req_val < modbus_server_pkg::QTY_MIN
                || req_val > modbus_server_pkg::QTY_MAX) begin
              exc_nxt = modbus_server_pkg::EXC_ILL_VALUE;
            end else if (read_end > modbus_server_pkg::TABLE_SIZE) begin
              exc_nxt = modbus_server_pkg::EXC_ILL_ADDR;
            end else begin
              kind_nxt = modbus_server_pkg::KIND_READ;
              rfc_nxt = buf_r[1];
              body_nxt = modbus_server_pkg::HDR_BYTES
                + {req_val[7:0], 1'b0};
            end
          end else if (buf_r[1] == modbus_server_pkg::FC_WRITE) begin
            if (len_r != modbus_server_pkg::REQ_LEN) begin
              exc_nxt = modbus_server_pkg::EXC_ILL_VALUE;
            end else if ({1'b0, req_addr}
                >= modbus_server_pkg::TABLE_SIZE) begin
              exc_nxt = modbus_server_pkg::EXC_ILL_ADDR;
            end else begin
              // store first; the echo starts only afterwards
              kind_nxt = modbus_server_pkg::KIND_WRITE;
              rfc_nxt = buf_r[1];
              body_nxt = modbus_server_pkg::ECHO_BYTES;
              reg_wr_nxt = 1'b1;
              reg_addr_nxt = req_addr;
              reg_wdata_nxt = req_val;
            end
          end else begin
            exc_nxt = modbus_server_pkg::EXC_ILL_FUNC;
          end
        end
      end
      ST_LOAD: begin
        // pick the byte at idx; register words are fetched on demand
        state_nxt = ST_SEND;
        tx_valid_nxt = 1'b1;
        if (idx_r == body_r) begin
          crc_hold_nxt = crc_val;
          tx_byte_nxt = crc_val[7:0];
        end else if (idx_r == body_r + 9'h001) begin
          tx_byte_nxt = crc_hold_r[15:8];
        end else if (idx_r == 9'h000) begin
          tx_byte_nxt = buf_r[0];
        end else if (idx_r == 9'h001) begin
          tx_byte_nxt = rfc_r;
        end else if (kind_r == modbus_server_pkg::KIND_EXC) begin
          tx_byte_nxt = exc_r;
        end else if (kind_r == modbus_server_pkg::KIND_WRITE) begin
          tx_byte_nxt = buf_r[idx_r[2:0]];
        end else if (idx_r == 9'h002) begin
          tx_byte_nxt = {req_val[6:0], 1'b0};
        end else if (!k[0] && !word_ok_r) begin
          state_nxt = ST_FETCH;
          tx_valid_nxt = 1'b0;
          reg_rd_nxt = 1'b1;
          reg_addr_nxt = req_addr + {8'h00, k[8:1]};
        end else begin
          tx_byte_nxt = k[0] ? word_r[7:0] : word_r[15:8];
        end
      end
      ST_FETCH: begin
        state_nxt = ST_GRAB; // read data arrives one cycle after strobe
      end
      ST_GRAB: begin
        word_nxt = reg_rdata_i;
        word_ok_nxt = 1'b1;
        state_nxt = ST_LOAD;
      end
      ST_SEND: begin
        if (tx_ready_i) begin
          tx_valid_nxt = 1'b0;
          crc_data = tx_byte_r;
          crc_en = (idx_r < body_r);
          if (k[0]) begin
            word_ok_nxt = 1'b0; // low byte gone, next word must be read
          end
          idx_nxt = idx_r + 9'h001;
          state_nxt = (idx_r == body_r + 9'h001) ? ST_IDLE : ST_LOAD;
        end
      end
    endcase
  end

  // registers of the interpreter; every output is one of these
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state_r <= ST_IDLE;
      gap_r <= '0;
      len_r <= '0;
      bad_r <= 1'b0;
      for (int i = 0; i < modbus_server_pkg::BUF_BYTES; i++) begin
        buf_r[i] <= modbus_server_pkg::BYTE_RST;
      end
      kind_r <= modbus_server_pkg::KIND_EXC;
      rfc_r <= modbus_server_pkg::BYTE_RST;
      exc_r <= modbus_server_pkg::BYTE_RST;
      body_r <= '0;
      idx_r <= '0;
      word_r <= modbus_server_pkg::WORD_RST;
      word_ok_r <= 1'b0;
      crc_hold_r <= modbus_server_pkg::WORD_RST;
      tx_byte_r <= modbus_server_pkg::BYTE_RST;
      tx_valid_r <= 1'b0;
      reg_addr_r <= modbus_server_pkg::WORD_RST;
      reg_rd_r <= 1'b0;
      reg_wr_r <= 1'b0;
      reg_wdata_r <= modbus_server_pkg::WORD_RST;
    end else begin
      state_r <= state_nxt;
      gap_r <= gap_nxt;
      len_r <= len_nxt;
      bad_r <= bad_nxt;
      buf_r <= buf_nxt;
      kind_r <= kind_nxt;
      rfc_r <= rfc_nxt;
      exc_r <= exc_nxt;
      body_r <= body_nxt;
      idx_r <= idx_nxt;
      word_r <= word_nxt;
      word_ok_r <= word_ok_nxt;
      crc_hold_r <= crc_hold_nxt;
      tx_byte_r <= tx_byte_nxt;
      tx_valid_r <= tx_valid_nxt;
      reg_addr_r <= reg_addr_nxt;
      reg_rd_r <= reg_rd_nxt;
      reg_wr_r <= reg_wr_nxt;
      reg_wdata_r <= reg_wdata_nxt;
    end
  end

  assign tx_byte_o = tx_byte_r;
  assign tx_valid_o = tx_valid_r;
  assign reg_addr_o = reg_addr_r;
  assign reg_rd_o = reg_rd_r;
  assign reg_wr_o = reg_wr_r;
  assign reg_wdata_o = reg_wdata_r;
endmodule

// ### server_checker_properties.sv
// assertion checker bound to the holding register server ports
`timescale 1ns/1ps
module server_checker #(
  parameter int SILENCE_CYCLES = 20
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic rx_valid_i,
  input wire logic [7:0] tx_byte_o,
  input wire logic tx_valid_o,
  input wire logic tx_ready_i,
  input wire logic [15:0] reg_addr_o,
  input wire logic reg_rd_o,
  input wire logic reg_wr_o
);
  logic [31:0] quiet_r;
  logic [31:0] quiet_nxt;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  // cycles since the last character; wraps only after minutes of silence
  always_comb quiet_nxt = rx_valid_i ? 32'h0 : quiet_r + 32'h1;
  always_ff @(posedge mclk_i) quiet_r <= rst_i ? 32'h0 : quiet_nxt;
  // a fetched word reaches the line three cycles after its strobe
  sequence fetch_s;
    ##3 tx_valid_o;
  endsequence
  // the echo may start only once the store strobe has gone out
  sequence echo_s;
    !tx_valid_o ##[1:2] tx_valid_o;
  endsequence
  a_rd_pulse: assert property (reg_rd_o |=> !reg_rd_o)
    else $error("read strobe longer than one cycle");
  a_wr_pulse: assert property (reg_wr_o |=> !reg_wr_o)
    else $error("write strobe longer than one cycle");
  a_strobe_excl: assert property (!(reg_rd_o && reg_wr_o))
    else $error("read and write strobes together");
  a_tx_hold: assert property (tx_valid_o && !tx_ready_i |=>
    tx_valid_o && $stable(tx_byte_o))
    else $error("answer byte changed before it was taken");
  a_tx_drop: assert property (tx_valid_o && tx_ready_i |=>
    !tx_valid_o)
    else $error("answer byte offered twice");
  a_fetch_tx: assert property (reg_rd_o |-> fetch_s)
    else $error("fetched word not offered in time");
  a_echo_after: assert property (reg_wr_o |-> echo_s)
    else $error("echo not placed after the store");
  a_rd_range: assert property (reg_rd_o |->
    reg_addr_o < modbus_server_pkg::TABLE_SIZE[15:0])
    else $error("read beyond the table");
  a_wr_range: assert property (reg_wr_o |->
    reg_addr_o < modbus_server_pkg::TABLE_SIZE[15:0])
    else $error("write beyond the table");
  a_silence: assert property ($rose(tx_valid_o) |->
    quiet_r > SILENCE_CYCLES)
    else $error("answer began before the frame ended");
endmodule

bind modbus_rtu_register_server server_checker #(
  .SILENCE_CYCLES(SILENCE_CYCLES)
) chk (
  .mclk_i(mclk_i), .rst_i(rst_i), .rx_valid_i(rx_valid_i),
  .tx_byte_o(tx_byte_o), .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i),
  .reg_addr_o(reg_addr_o), .reg_rd_o(reg_rd_o), .reg_wr_o(reg_wr_o)
);

// ### rtu_master.sv
// serial-line master model: sends request frames, collects answers
`timescale 1ns/1ps
module rtu_master (
  input wire logic mclk_i,
  input wire logic [7:0] tx_byte_i,
  input wire logic tx_valid_i,
  output logic [7:0] rx_byte_o = 8'h00,
  output logic rx_valid_o = 1'b0,
  output logic rx_err_o = 1'b0,
  output logic tx_ready_o = 1'b0
);
  logic [7:0] got [$];
  logic slow = 1'b0;
  logic [1:0] tick = 2'h0;
  // frame check sum, reflected, one byte at a time
  function automatic logic [15:0] crc16(input logic [7:0] q [$]);
    logic [15:0] c;
    c = modbus_server_pkg::CRC_INIT;
    foreach (q[i]) begin
      c = c ^ {8'h00, q[i]};
      for (int k = 0; k < 8; k++) begin
        c = c[0] ? (c >> 1) ^ modbus_server_pkg::CRC_POLY : c >> 1;
      end
    end
    return c;
  endfunction
  // characters two cycles apart, well inside the silence gap
  task automatic send(input logic [7:0] q [$], input logic [15:0] bad,
      input logic err);
    logic [15:0] c;
    c = crc16(q) ^ bad;
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    foreach (q[i]) begin
      @(posedge mclk_i);
      rx_byte_o <= q[i];
      rx_valid_o <= 1'b1;
      rx_err_o <= err;
      @(posedge mclk_i);
      rx_valid_o <= 1'b0;
      rx_byte_o <= ~q[i]; // idle line must not repeat the byte
      rx_err_o <= 1'b0;
    end
  endtask
  // take answer bytes; a slow sender stalls half of the cycles
  always @(posedge mclk_i) begin
    tick <= tick + 2'h1;
    if (tx_valid_i && tx_ready_o) got.push_back(tx_byte_i);
    tx_ready_o <= !slow || tick[1];
  end
endmodule

// ### tb.sv
// self-checking bench for the holding register server
`timescale 1ns/1ps
module tb;
  localparam int SIL = 20;
  localparam logic [7:0] NODE = 8'h64;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] rx_byte_i;
  logic rx_valid_i;
  logic rx_err_i;
  logic tx_ready_i;
  logic [7:0] tx_byte_o;
  logic tx_valid_o;
  logic [15:0] reg_addr_o;
  logic reg_rd_o;
  logic reg_wr_o;
  logic [15:0] reg_wdata_o;
  logic [15:0] reg_rdata_i = 16'h0000;
  logic [15:0] mem [0:63];
  logic [7:0] none [$];
  int fail_count = 0;
  int comparisons = 0;
  always #25 mclk_i = ~mclk_i;
  modbus_rtu_register_server #(.SILENCE_CYCLES(SIL)) DUT (
    .mclk_i(mclk_i), .rst_i(rst_i), .node_addr_i(NODE),
    .rx_byte_i(rx_byte_i), .rx_valid_i(rx_valid_i), .rx_err_i(rx_err_i),
    .tx_byte_o(tx_byte_o), .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i),
    .reg_addr_o(reg_addr_o), .reg_rd_o(reg_rd_o), .reg_wr_o(reg_wr_o),
    .reg_wdata_o(reg_wdata_o), .reg_rdata_i(reg_rdata_i));
  rtu_master m (
    .mclk_i(mclk_i), .tx_byte_i(tx_byte_o), .tx_valid_i(tx_valid_o),
    .rx_byte_o(rx_byte_i), .rx_valid_o(rx_valid_i), .rx_err_o(rx_err_i),
    .tx_ready_o(tx_ready_i));
  // holding table: data only in the cycle after a read strobe
  always @(posedge mclk_i) begin
    if (reg_wr_o) mem[reg_addr_o[5:0]] <= reg_wdata_o;
    reg_rdata_i <= reg_rd_o ? mem[reg_addr_o[5:0]] : ~reg_rdata_i;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp,
      input string what);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  // one request, then the whole answer byte by byte, check sum included
  task automatic xact(input logic [7:0] q [$], input logic [7:0] e [$],
      input logic [15:0] bad, input logic err);
    logic [15:0] c;
    m.got.delete();
    m.send(q, bad, err);
    c = m.crc16(e);
    if (e.size() > 0) e = {e, c[7:0], c[15:8]};
    for (int n = 0; n < 4000 && m.got.size() < e.size(); n++)
      @(posedge mclk_i);
    repeat (2 * SIL + 20) @(posedge mclk_i);
    check(16'(m.got.size()), 16'(e.size()), "answer length");
    foreach (e[i]) if (i < m.got.size())
      check({8'h00, m.got[i]}, {8'h00, e[i]}, "answer byte");
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] n,
      input logic [7:0] code);
    logic [7:0] q [$];
    logic [7:0] e [$];
    q = {NODE, modbus_server_pkg::FC_READ, a[15:8], a[7:0], n[15:8], n[7:0]};
    e = {NODE, modbus_server_pkg::FC_READ, 8'(2 * n)};
    if (code != 8'h00) e = {NODE, 8'h83, code};
    else for (int i = 0; i < n; i++)
      e = {e, mem[a + i][15:8], mem[a + i][7:0]};
    xact(q, e, 16'h0000, 1'b0);
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] v,
      input logic ok);
    logic [7:0] q [$];
    logic [7:0] e [$];
    logic [15:0] old;
    old = mem[a[5:0]];
    q = {NODE, modbus_server_pkg::FC_WRITE, a[15:8], a[7:0], v[15:8], v[7:0]};
    e = q;
    if (!ok) e = {NODE, 8'h86, 8'h02};
    xact(q, e, 16'h0000, 1'b0);
    check(mem[a[5:0]], ok ? v : old, "stored word");
  endtask
  // five words under a stalling sender, then the last word of the table
  task automatic t_read();
    m.slow = 1'b1;
    rd(16'h0001, 16'h0005, 8'h00);
    m.slow = 1'b0;
    rd(16'h002b, 16'h0001, 8'h00);
  endtask
  // quantity is judged before the end of the table
  task automatic t_limits();
    rd(16'h002b, 16'h0002, 8'h02);
    rd(16'h0000, 16'h0000, 8'h03);
    rd(16'h0000, 16'h007e, 8'h03);
    rd(16'h0000, 16'h007d, 8'h02);
  endtask
  // a frame too short or too long for its code: illegal data value
  task automatic t_length();
    logic [7:0] q [$];
    logic [7:0] e [$];
    logic [15:0] old;
    old = mem[1];
    q = {NODE, modbus_server_pkg::FC_READ, 8'h00, 8'h00, 8'h00};
    e = {NODE, 8'h83, 8'h03};
    xact(q, e, 16'h0000, 1'b0);
    q = {NODE, modbus_server_pkg::FC_WRITE, 8'h00, 8'h01, 8'h12, 8'h34,
      8'h00};
    e = {NODE, 8'h86, 8'h03};
    xact(q, e, 16'h0000, 1'b0);
    check(mem[1], old, "word after bad write");
  endtask
  task automatic t_write();
    wr(16'h000f, 16'h0032, 1'b1);
    wr(16'h002b, 16'hbeef, 1'b1);
    wr(16'h002c, 16'h1234, 1'b0);
    rd(16'h000f, 16'h0001, 8'h00);
  endtask
  task automatic t_badfc();
    logic [7:0] fc [6] = '{8'h00, 8'h01, 8'h04, 8'h10, 8'h41, 8'h7f};
    logic [7:0] q [$];
    logic [7:0] e [$];
    foreach (fc[i]) begin
      q = {NODE, fc[i], 8'h00, 8'h00, 8'h00, 8'h01};
      e = {NODE, fc[i] | 8'h80, 8'h01};
      xact(q, e, 16'h0000, 1'b0);
    end
  endtask
  // other node, damaged check sum, flagged character: all unanswered
  task automatic t_drop();
    logic [7:0] q [$];
    q = {NODE + 8'h01, modbus_server_pkg::FC_READ, 8'h00, 8'h00, 8'h00,
      8'h01};
    xact(q, none, 16'h0000, 1'b0);
    q[0] = NODE;
    xact(q, none, 16'h0100, 1'b0);
    xact(q, none, 16'h0000, 1'b1);
    q = {NODE};
    xact(q, none, 16'h0000, 1'b0);
    rd(16'h0000, 16'h0001, 8'h00);
  endtask
  // reset in mid-answer: outputs low after five cycles of reset, next request still served
  task automatic t_reset();
    logic [7:0] q [$];
    logic [15:0] outs;
    q = {NODE, modbus_server_pkg::FC_READ, 8'h00, 8'h00, 8'h00, 8'h01};
    m.send(q, 16'h0000, 1'b0);
    for (int n = 0; n < 200 && !tx_valid_o; n++) @(posedge mclk_i);
    check({15'h0000, tx_valid_o}, 16'h0001, "answer started");
    rst_i <= 1'b1;
    repeat (5) @(posedge mclk_i);
    outs = {tx_byte_o, 5'h00, tx_valid_o, reg_rd_o, reg_wr_o};
    check(outs, 16'h0000, "outputs in reset");
    check(reg_addr_o, 16'h0000, "address in reset");
    rst_i <= 1'b0;
    repeat (SIL + 5) @(posedge mclk_i);
    rd(16'h0002, 16'h0002, 8'h00);
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // watchdog: the whole run needs well under 20000 cycles
  initial begin
    repeat (30000) @(posedge mclk_i);
    fail_count++;
    close_out();
  end
  initial begin
    for (int i = 0; i < 64; i++) mem[i] = 16'(i * 16'h0301) ^ 16'ha55a;
    repeat (5) @(posedge mclk_i);
    rst_i <= 1'b0;
    repeat (SIL + 5) @(posedge mclk_i);
    t_read();
    t_limits();
    t_length();
    t_write();
    t_badfc();
    t_drop();
    t_reset();
    close_out();
  end
endmodule
